// ---- hdl/akr_angle_readout.sv ----
// Angle readout core: angle refresh, serial register port and power-up load.
//
// Functional notes
// - Refresh the internal angle once per microsecond.
// - Register address read selects 12 or 15-bit format.
// - Address 0x20 returns 0, error, undervoltage, parity, angle.
// - Address 0x32 returns 0 and 15-bit angle.
// - Every 12-bit read carries three status bits.
// - PWM uses 12 bits; encoder outputs use 15.
// - Subtract stored zero offset from reported angle.
// - Each update reflects magnet one latency earlier.
// - Capture response on first serial clock edge.
// - PWM latches angle at each carrier period start.
// - Main path plus separate low-power path.
// - Low-power angle register updates every 32 us.
// - Field strength at 0x2A updates every 128 us.
// - Run power-on initialization before normal operation.
// - Power-up reloads shadow offset, resets serial registers.
// - Power-up clears extended write address to zero.
// - New angle ready every 1.0 us.
// - Angle latency is typically 7 us.
`timescale 1ns/1ps
module akr_angle_readout
  import akr_pkg::*;
#(
  parameter int PO_CYCLES  = PO_TIME_NS / CLK_PERIOD_NS,
  parameter int PWM_PERIOD = PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic               MCLK,
  input  wire logic               RESETN,
  // Main signal path sample
  input  wire logic [ANGLE_W-1:0] MAIN_ANGLE,
  // Low-power signal path samples
  input  wire logic [ANGLE_W-1:0] LP_ANGLE,
  input  wire logic [ANGLE_W-1:0] FIELD_LEVEL,
  // Diagnostic levels
  input  wire logic               ERROR_IN,
  input  wire logic               UNDERVOLTAGE_IN,
  // Nonvolatile zero offset
  input  wire logic [ANGLE_W-1:0] NVM_ZERO_OFFSET,
  // Serial port
  input  wire logic               SCLK,
  input  wire logic               CS_N,
  input  wire logic               MOSI,
  output logic                    MISO,
  output logic                    MISO_OE_N,
  // Encoder and commutation angle
  output logic [ANGLE_W-1:0]      ENC_ANGLE,
  // Pulse-width open-drain pin
  output logic                    PWM_O,
  output logic                    PWM_OE_N,
  // Status
  output logic                    INIT_DONE
);

  localparam int PO_W  = $clog2(PO_CYCLES + 1);
  localparam int ACN_W = $clog2(ANG_CYCLES);
  localparam int LPC_W = $clog2(LP_TICKS);
  localparam int FDC_W = $clog2(FIELD_TICKS);
  localparam int GAP_W = $clog2(FIELD_CYCLES + 1);

  akr_init_e state;
  akr_init_e next_state;

  logic [PO_W-1:0]        po_cnt;
  logic [ACN_W-1:0]       ang_cnt;
  logic                   tick;
  logic [LPC_W-1:0]       lp_cnt;
  logic [FDC_W-1:0]       field_cnt;
  logic                   lp_upd;
  logic                   field_upd;

  logic [ANGLE_W-1:0]     dly_angle;
  logic [ANGLE_W-1:0]     zero_offset;
  logic [ANGLE_W-1:0]     angle_long;
  logic [ANGLE_W-1:0]     lp_angle;
  logic [ANGLE_W-1:0]     field_strength;
  logic                   general_error_flag;
  logic                   undervoltage_flag;
  logic [7:0]             write_adr;

  logic                   short_par;
  logic [FRAME_BITS-1:0]  short_word;
  logic [FRAME_BITS-1:0]  resp_word;

  logic                   sclk_q;
  logic                   csn_q;
  logic                   cs_fall;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   captured;
  logic                   first_rise;
  logic                   frame_end;
  logic [3:0]             bit_cnt;
  logic [FRAME_BITS-2:0]  rx;
  logic [FRAME_BITS-1:0]  cmd;
  logic [FRAME_BITS-1:0]  tx;
  logic [6:0]             rd_addr;

  // Power-up sequence: wait the power-on time, load shadow copies, then run.
  always_comb begin
    next_state = state;
    case (state)
      ST_POWER: begin
        if (po_cnt == PO_W'(PO_CYCLES - 1)) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_POWER;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_POWER;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      po_cnt <= '0;
    end else if (state == ST_POWER) begin
      po_cnt <= po_cnt + 1'b1;
    end
  end

  assign INIT_DONE = (state == ST_RUN);

  // The offset is caught by a clocked load after reset, never by the reset itself.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      zero_offset <= '0;
    end else if (state == ST_LOAD) begin
      zero_offset <= NVM_ZERO_OFFSET;
    end
  end

  // Refresh tick: exactly one per ANG_CYCLES clocks while running.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ang_cnt <= '0;
    end else if (state != ST_RUN || tick) begin
      ang_cnt <= '0;
    end else begin
      ang_cnt <= ang_cnt + 1'b1;
    end
  end

  assign tick = (state == ST_RUN) && (ang_cnt == ACN_W'(ANG_CYCLES - 1));

  // Main path: samples age through the latency line before they are reported.
  akr_delay #(
    .W     (ANGLE_W),
    .DEPTH (LATENCY_TICKS)
  ) u_delay (
    .clk   (MCLK),
    .rst_n (RESETN),
    .shift (tick),
    .d     (MAIN_ANGLE),
    .q     (dly_angle)
  );

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      angle_long <= '0;
    end else if (state == ST_LOAD) begin
      angle_long <= '0;
    end else if (tick) begin
      angle_long <= dly_angle - zero_offset;
    end
  end

  assign ENC_ANGLE = angle_long;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      general_error_flag <= 1'b0;
      undervoltage_flag  <= 1'b0;
    end else if (state == ST_LOAD) begin
      general_error_flag <= 1'b0;
      undervoltage_flag  <= 1'b0;
    end else if (tick) begin
      general_error_flag <= ERROR_IN;
      undervoltage_flag  <= UNDERVOLTAGE_IN;
    end
  end

  // Low-power path runs on slower sub-multiples of the refresh tick.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lp_cnt    <= '0;
      field_cnt <= '0;
    end else if (state != ST_RUN) begin
      lp_cnt    <= '0;
      field_cnt <= '0;
    end else if (tick) begin
      lp_cnt    <= lp_upd ? '0 : lp_cnt + 1'b1;
      field_cnt <= field_upd ? '0 : field_cnt + 1'b1;
    end
  end

  assign lp_upd    = tick && (lp_cnt == LPC_W'(LP_TICKS - 1));
  assign field_upd = tick && (field_cnt == FDC_W'(FIELD_TICKS - 1));

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      lp_angle <= '0;
    end else if (state == ST_LOAD) begin
      lp_angle <= '0;
    end else if (lp_upd) begin
      lp_angle <= LP_ANGLE;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      field_strength <= '0;
    end else if (state == ST_LOAD) begin
      field_strength <= '0;
    end else if (field_upd) begin
      field_strength <= FIELD_LEVEL;
    end
  end

  // Short word: the 12-bit angle is the top of the 15-bit one.
  assign short_par  = ~^{general_error_flag, undervoltage_flag, angle_long[ANGLE_W-1 -: SHORT_W]};
  assign short_word = {1'b0, general_error_flag, undervoltage_flag, short_par,
                       angle_long[ANGLE_W-1 -: SHORT_W]};

  always_comb begin
    case (rd_addr)
      ADR_SHORT: resp_word = short_word;
      ADR_LONG:  resp_word = {1'b0, angle_long};
      ADR_LP:    resp_word = {1'b0, lp_angle};
      ADR_FIELD: resp_word = {1'b0, field_strength};
      ADR_WADR:  resp_word = {8'h00, write_adr};
      default:   resp_word = 16'h0000;
    endcase
  end

  // Serial port: pins are synchronous to MCLK, edges found by one previous sample.
  assign cs_fall    = csn_q && !CS_N;
  assign sclk_rise  = !CS_N && SCLK && !sclk_q;
  assign sclk_fall  = !CS_N && !SCLK && sclk_q;
  assign first_rise = sclk_rise && !captured;
  assign frame_end  = sclk_rise && (bit_cnt == 4'hF);
  assign cmd        = {rx, MOSI};

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_q <= 1'b0;
      csn_q  <= 1'b1;
    end else begin
      sclk_q <= SCLK;
      csn_q  <= CS_N;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt  <= '0;
      captured <= 1'b0;
      rx       <= '0;
    end else if (CS_N || cs_fall) begin
      bit_cnt  <= '0;
      captured <= 1'b0;
    end else if (sclk_rise) begin
      bit_cnt  <= bit_cnt + 1'b1;
      captured <= 1'b1;
      rx       <= {rx[FRAME_BITS-3:0], MOSI};
    end
  end

  // Bit 15 of every response is zero, so the line idles low until the capture.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tx <= '0;
    end else if (cs_fall) begin
      tx <= '0;
    end else if (first_rise) begin
      tx <= resp_word;
    end else if (sclk_fall) begin
      tx <= {tx[FRAME_BITS-2:0], 1'b0};
    end
  end

  assign MISO      = tx[FRAME_BITS-1];
  assign MISO_OE_N = CS_N;

  // A complete read frame names the register returned in the following frame.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_addr <= ADR_SHORT;
    end else if (state == ST_LOAD) begin
      rd_addr <= ADR_SHORT;
    end else if (frame_end && !cmd[FRAME_BITS-1]) begin
      rd_addr <= cmd[14:8];
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      write_adr <= WRITE_ADR_RST;
    end else if (state == ST_LOAD) begin
      write_adr <= WRITE_ADR_RST;
    end else if (frame_end && cmd[FRAME_BITS-1] && cmd[14:8] == ADR_WADR) begin
      write_adr <= cmd[7:0];
    end
  end

  // Carrier starts only once initialization is over.
  akr_pwm #(
    .PERIOD   (PWM_PERIOD)
  ) u_pwm (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .run      (INIT_DONE),
    .angle    (angle_long[ANGLE_W-1 -: SHORT_W]),
    .pwm_o    (PWM_O),
    .pwm_oe_n (PWM_OE_N)
  );

  // Helper: clocks since the previous field update.
  logic [GAP_W-1:0] field_gap;
  logic             field_seen;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      field_gap  <= '0;
      field_seen <= 1'b0;
    end else if (field_upd) begin
      field_gap  <= '0;
      field_seen <= 1'b1;
    end else if (field_gap != GAP_W'(FIELD_CYCLES)) begin
      field_gap <= field_gap + 1'b1;
    end
  end

  tick_period_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tick |-> ##200 tick)
    else $error("angle refresh period is not 200 clocks");

  zero_adjust_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    tick |=> angle_long == $past(dly_angle) - zero_offset)
    else $error("reported angle misses zero offset");

  short_layout_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (first_rise && rd_addr == ADR_SHORT) |=>
      tx[15] == 1'b0 && tx[BIT_ERR] == $past(general_error_flag) && tx[BIT_LOWV] == $past(undervoltage_flag) &&
      tx[11:0] == $past(angle_long[ANGLE_W-1 -: SHORT_W]))
    else $error("short angle word layout wrong");

  long_layout_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (first_rise && rd_addr == ADR_LONG) |=> tx == {1'b0, $past(angle_long)})
    else $error("long angle word layout wrong");

  parity_odd_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (first_rise && rd_addr == ADR_SHORT) |=> (^tx) && tx[BIT_PAR] == $past(short_par))
    else $error("short word parity is not odd");

  frame_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (captured && !CS_N && !sclk_fall && !cs_fall) |=> $stable(tx))
    else $error("response changed inside a frame");

  field_rate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    (field_upd && field_seen) |-> field_gap == GAP_W'(FIELD_CYCLES - 1))
    else $error("field strength update spacing wrong");

  lp_rate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    lp_upd |=> !lp_upd [*8])
    else $error("low-power angle updated too often");

  power_load_a: assert property (@(posedge MCLK) disable iff (!RESETN)
    state == ST_LOAD |=> zero_offset == $past(NVM_ZERO_OFFSET) && write_adr == WRITE_ADR_RST &&
      state == ST_RUN && angle_long == '0)
    else $error("power-up load did not restore shadow state");

endmodule

// ---- hdl/akr_pkg.sv ----
// Constants, register map and types shared by the angle readout block.
package akr_pkg;

  // Clock and angle refresh timing.
  localparam int CLK_PERIOD_NS   = 5;
  localparam int ANG_PERIOD_NS   = 1000;
  localparam int ANG_CYCLES      = (ANG_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATENCY_NS      = 7000;
  localparam int LATENCY_TICKS   = LATENCY_NS / ANG_PERIOD_NS;
  localparam int LP_PERIOD_NS    = 32000;
  localparam int LP_TICKS        = LP_PERIOD_NS / ANG_PERIOD_NS;
  localparam int FIELD_PERIOD_NS = 128000;
  localparam int FIELD_TICKS     = FIELD_PERIOD_NS / ANG_PERIOD_NS;
  localparam int FIELD_CYCLES    = FIELD_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PO_TIME_NS      = 100000;

  // Pulse-width output timing.
  localparam int PWM_FREQ_HZ       = 3125;
  localparam int PWM_PERIOD_CYCLES = 1000000000 / PWM_FREQ_HZ / CLK_PERIOD_NS;
  localparam int PWM_EDGE_PCT      = 5;

  // Data widths and field positions.
  localparam int ANGLE_W    = 15;
  localparam int SHORT_W    = 12;
  localparam int FRAME_BITS = 16;
  localparam int BIT_ERR    = 14;
  localparam int BIT_LOWV   = 13;
  localparam int BIT_PAR    = 12;

  // Serial register addresses and reset values.
  localparam logic [6:0] ADR_WADR      = 7'h02;
  localparam logic [6:0] ADR_SHORT     = 7'h20;
  localparam logic [6:0] ADR_LP        = 7'h22;
  localparam logic [6:0] ADR_FIELD     = 7'h2A;
  localparam logic [6:0] ADR_LONG      = 7'h32;
  localparam logic [7:0] WRITE_ADR_RST = 8'h00;

  // Power-up sequence, Gray coded along the only path.
  typedef enum logic [1:0] {
    ST_POWER = 2'b00,
    ST_LOAD  = 2'b01,
    ST_RUN   = 2'b11
  } akr_init_e;

endpackage

// ---- hdl/akr_delay.sv ----
// Signal path latency line: one stage per angle refresh tick.
`timescale 1ns/1ps
module akr_delay
  import akr_pkg::*;
#(
  parameter int W     = ANGLE_W,
  parameter int DEPTH = LATENCY_TICKS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Sample stream
  input  wire logic         shift,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [DEPTH-1:0][W-1:0] pipe;

  // Each refresh pushes the newest sample; the oldest leaves DEPTH ticks later.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe <= '0;
    end else if (shift) begin
      pipe <= {pipe[DEPTH-2:0], d};
    end
  end

  assign q = pipe[DEPTH-1];

  stage_age_a: assert property (@(posedge clk) disable iff (!rst_n)
    shift |=> (pipe[0] == $past(d)) && (q == $past(pipe[DEPTH-2])))
    else $error("latency line did not advance by one stage");

endmodule

// ---- hdl/akr_pwm.sv ----
// Pulse-width carrier: angle latched at each period start, 5/90/5 duty frame.
`timescale 1ns/1ps
module akr_pwm
  import akr_pkg::*;
#(
  parameter int PERIOD = PWM_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Angle source
  input  wire logic               run,
  input  wire logic [SHORT_W-1:0] angle,
  // Open-drain pin
  output logic                    pwm_o,
  output logic                    pwm_oe_n
);

  localparam int CW   = $clog2(PERIOD);
  localparam int EDGE = PERIOD * PWM_EDGE_PCT / 100;
  localparam int SPAN = PERIOD - 2 * EDGE;

  logic [CW-1:0]      cnt;
  logic [SHORT_W-1:0] lat;
  logic [CW-1:0]      high_len;
  logic               start;

  assign start    = run && (cnt == '0);
  assign high_len = CW'(EDGE + ((SPAN * int'(lat)) >> SHORT_W));
  assign pwm_o    = 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!run || cnt == CW'(PERIOD - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // The carrier is free running, so the angle is frozen for one full period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat <= '0;
    end else if (start) begin
      lat <= angle;
    end
  end

  // The pin is released (pulled high) during the high part of the period.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_oe_n <= 1'b0;
    end else begin
      pwm_oe_n <= run && (cnt < high_len);
    end
  end

  carrier_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    start |=> (lat == $past(angle)) ##1 pwm_oe_n)
    else $error("carrier start did not latch angle and rise");

endmodule

// ---- test/akr_host.sv ----
// Host controller model that runs serial frames against the angle readout port.
`timescale 1ns/1ps
module akr_host (
  // Clock
  input  wire logic clk,
  // Serial port
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  // Four clocks a level keeps every serial level well above the two-clock minimum.
  localparam int HALF = 4;
  logic oe_lost;
  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b1;
    oe_lost = 1'b0;
  end
  // Data in idles at the inverse of its last bit, so a stale bit is never mistaken for a fresh one.
  task automatic frame(input logic [15:0] cmd, input int nbits, output logic [15:0] resp);
    resp = 16'h0000;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      mosi <= cmd[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      resp[i] = miso;
      oe_lost = oe_lost | miso_oe_n;
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi;
    repeat (HALF) @(posedge clk);
  endtask
endmodule

// ---- test/akr_angle_readout_tb.sv ----
// Self-checking bench for the angle readout block driven through a host serial model.
`timescale 1ns/1ps
module akr_angle_readout_tb;
  import akr_pkg::*;
  localparam int          PO   = 10;
  localparam int          PER  = 200;
  localparam int          TICK = ANG_CYCLES;
  localparam logic [14:0] OFS  = 15'h0123;
  logic               MCLK, RESETN, SCLK, CS_N, MOSI, MISO, MISO_OE_N;
  logic               PWM_O, PWM_OE_N, INIT_DONE, ERROR_IN, UNDERVOLTAGE_IN;
  logic [ANGLE_W-1:0] MAIN_ANGLE, LP_ANGLE, FIELD_LEVEL, NVM_ZERO_OFFSET, ENC_ANGLE;
  logic [15:0]        rd;
  logic [14:0]        ang [4] = '{15'h1000, 15'h7FFF, 15'h0123, 15'h2AAB};
  int                 num_errors, n_compared, n;

  akr_angle_readout #(.PO_CYCLES(PO), .PWM_PERIOD(PER)) dut (
    .MCLK(MCLK), .RESETN(RESETN), .MAIN_ANGLE(MAIN_ANGLE), .LP_ANGLE(LP_ANGLE),
    .FIELD_LEVEL(FIELD_LEVEL), .ERROR_IN(ERROR_IN), .UNDERVOLTAGE_IN(UNDERVOLTAGE_IN),
    .NVM_ZERO_OFFSET(NVM_ZERO_OFFSET), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE_N(MISO_OE_N), .ENC_ANGLE(ENC_ANGLE), .PWM_O(PWM_O), .PWM_OE_N(PWM_OE_N),
    .INIT_DONE(INIT_DONE));
  akr_host host (.clk(MCLK), .sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO), .miso_oe_n(MISO_OE_N));

  always #2.5 MCLK = ~MCLK;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The response of a frame belongs to the previous command, so a read takes two frames.
  task automatic rd_reg(input logic [6:0] adr, output logic [15:0] v);
    host.frame({1'b0, adr, 8'h00}, 16, v);
    host.frame({1'b0, adr, 8'h00}, 16, v);
  endtask

  task automatic wr_reg(input logic [6:0] adr, input logic [7:0] d);
    logic [15:0] v;
    host.frame({1'b1, adr, d}, 16, v);
  endtask

  function automatic logic [15:0] short_word(logic [14:0] a, logic ef, logic uv);
    logic [15:0] w;
    w          = {1'b0, ef, uv, 1'b0, a[14:3]};
    w[BIT_PAR] = ~^w;
    return w;
  endfunction

  task automatic wait_enc(output int k);
    logic [14:0] p;
    p = ENC_ANGLE;
    k = 0;
    while (ENC_ANGLE === p && k < 4000) begin
      @(posedge MCLK);
      k++;
    end
  endtask

  task automatic wait_pwm(input logic lvl, output int k);
    k = 0;
    while (PWM_OE_N !== lvl && k < 1000) begin
      @(posedge MCLK);
      k++;
    end
  endtask

  task automatic test_done;
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge MCLK);
    num_errors++;
    test_done();
  end

  initial begin
    MCLK            = 1'b0;
    RESETN          = 1'b0;
    MAIN_ANGLE      = ang[0];
    LP_ANGLE        = 15'h2345;
    FIELD_LEVEL     = 15'h0567;
    ERROR_IN        = 1'b0;
    UNDERVOLTAGE_IN = 1'b0;
    NVM_ZERO_OFFSET = OFS;
    num_errors      = 0;
    n_compared      = 0;
    repeat (6) @(posedge MCLK);
    check("reset outputs", {ENC_ANGLE, INIT_DONE}, 16'h0000);
    RESETN <= 1'b1;
    repeat (PO + 1) @(posedge MCLK);
    check("init pending", {14'h0, PWM_OE_N, INIT_DONE}, 16'h0000);
    @(posedge MCLK);
    check("init done", {15'h0, INIT_DONE}, 16'h0001);
    rd_reg(ADR_WADR, rd);
    check("write address default", rd, 16'h0000);
    // Status flags and both angle formats over a table of angles.
    for (int k = 0; k < 4; k++) begin
      MAIN_ANGLE      <= ang[k];
      ERROR_IN        <= k[1];
      UNDERVOLTAGE_IN <= k[0];
      repeat (10 * TICK) @(posedge MCLK);
      check("encoder angle", {1'b0, ENC_ANGLE}, {1'b0, ang[k] - OFS});
      rd_reg(ADR_SHORT, rd);
      check("short angle", rd, short_word(ang[k] - OFS, k[1], k[0]));
      rd_reg(ADR_LONG, rd);
      check("long angle", rd, {1'b0, ang[k] - OFS});
    end
    check("data out enable", {15'h0, host.oe_lost}, 16'h0000);
    check("data out release", {15'h0, MISO_OE_N}, 16'h0001);
    // Refresh period and path latency, then capture at the first serial edge.
    host.frame({1'b0, ADR_LONG, 8'h00}, 16, rd);
    MAIN_ANGLE <= 15'h0F00;
    wait_enc(n);
    MAIN_ANGLE <= 15'h3C00;
    wait_enc(n);
    check("refresh latency", 16'(n), 16'(8 * TICK));
    MAIN_ANGLE <= 15'h5555;
    repeat (8 * TICK - 60) @(posedge MCLK);
    host.frame({1'b0, ADR_LONG, 8'h00}, 16, rd);
    check("frame capture", rd, {1'b0, 15'h3C00 - OFS});
    host.frame({1'b0, ADR_LONG, 8'h00}, 16, rd);
    check("next frame", rd, {1'b0, 15'h5555 - OFS});
    // Writes, read-only places, unmapped reads and a short frame.
    wr_reg(ADR_WADR, 8'hA5);
    rd_reg(ADR_WADR, rd);
    check("write address", rd, 16'h00A5);
    wr_reg(ADR_LONG, 8'h55);
    rd_reg(ADR_LONG, rd);
    check("read-only long", rd, {1'b0, 15'h5555 - OFS});
    rd_reg(7'h10, rd);
    check("unmapped", rd, 16'h0000);
    host.frame({1'b0, ADR_LONG, 8'h00}, 8, rd);
    host.frame({1'b0, ADR_LONG, 8'h00}, 16, rd);
    check("short frame ignored", rd, 16'h0000);
    // Slow low-power path registers.
    repeat (200 * TICK) @(posedge MCLK);
    rd_reg(ADR_LP, rd);
    check("low-power angle", rd, 16'h2345);
    rd_reg(ADR_FIELD, rd);
    check("field strength", rd, 16'h0567);
    // Pulse width: 12-bit angle 0x800 gives 10 + 90 released clocks of 200.
    MAIN_ANGLE <= 15'h4000 + OFS;
    repeat (10 * TICK + PER) @(posedge MCLK);
    wait_pwm(1'b0, n);
    wait_pwm(1'b1, n);
    wait_pwm(1'b0, n);
    check("pwm high time", 16'(n), 16'd100);
    wait_pwm(1'b1, n);
    check("pwm low time", 16'(n), 16'd100);
    check("pwm data", {15'h0, PWM_O}, 16'h0000);
    // A second power cycle must drop the written address and take the new stored offset.
    RESETN          <= 1'b0;
    NVM_ZERO_OFFSET <= 15'h0100;
    repeat (6) @(posedge MCLK);
    check("reset again", {ENC_ANGLE, INIT_DONE}, 16'h0000);
    RESETN <= 1'b1;
    repeat (PO + 2) @(posedge MCLK);
    rd_reg(ADR_WADR, rd);
    check("write address cleared", rd, 16'h0000);
    repeat (10 * TICK) @(posedge MCLK);
    check("offset reloaded", {1'b0, ENC_ANGLE}, {1'b0, 15'h4000 + OFS - 15'h0100});
    test_done();
  end
endmodule
